// ### design/ccch_channel.sv
/*
  one capture/compare channel of the counter array: capture, software
  timer, high-speed output, frequency output and 8..11-bit pwm.
  assumes the shared 16-bit counter and its advance enable come in as
  ports, writes from the processor arrive as one-cycle strobes with data,
  and the pin input may be asynchronous to core_clk_i.
*/
`timescale 1ns/1ns
`include "ccch_regs.svh"

module ccch_channel (
  // clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  // shared counter
  input  wire logic [15:0] counter_i,
  input  wire logic        count_en_i,
  // shared pwm control
  input  wire logic [1:0]  cycle_length_select_i,
  input  wire logic        reload_register_select_i,
  input  wire logic        overflow_int_en_i,
  input  wire logic        overflow_flag_clr_i,
  // processor writes
  input  wire logic        mode_wr_i,
  input  wire logic [7:0]  mode_wdata_i,
  input  wire logic        low_wr_i,
  input  wire logic        high_wr_i,
  input  wire logic [7:0]  byte_wdata_i,
  input  wire logic        event_flag_clr_i,
  // channel pin
  input  wire logic        channel_pin_i,
  output logic             channel_pin_o,
  // readback and status
  output logic [7:0]       channel_mode_register_o,
  output logic [7:0]       compare_low_byte_o,
  output logic [7:0]       compare_high_byte_o,
  output logic             channel_event_flag_o,
  output logic             intermediate_overflow_flag_o,
  output logic             irq_o
);

  // ****************************************************************
  // state
  // ****************************************************************
  logic [7:0]           mode_reg;
  logic [15:0]          cmp_reg;
  logic [15:0]          reload_reg;
  logic                 pin_reg;
  logic                 flag_reg;
  logic                 ovf_reg;
  logic                 sync1_reg;
  logic                 sync2_reg;
  logic                 sync3_reg;
  logic [15:0]          cnt_prev_reg;
  ccch_pkg::ccch_mode_t mode_now;

  logic ecom;
  logic mat;
  logic tog;
  logic pwm;
  logic capp;
  logic capn;
  assign ecom = mode_reg[`CCCH_MODE_ECOM];
  assign mat  = mode_reg[`CCCH_MODE_MAT];
  assign tog  = mode_reg[`CCCH_MODE_TOG];
  assign pwm  = mode_reg[`CCCH_MODE_PWM];
  assign capp = mode_reg[`CCCH_MODE_CAPP];
  assign capn = mode_reg[`CCCH_MODE_CAPN];

  // ****************************************************************
  // mode decode
  // ****************************************************************
  always_comb begin
    if (capp || capn) begin
      mode_now = ccch_pkg::CCCH_CAPTURE;
    end else if (pwm && tog) begin
      mode_now = ccch_pkg::CCCH_FREQ;
    end else if (pwm) begin
      mode_now = ccch_pkg::CCCH_PWM;
    end else if (tog) begin
      mode_now = ccch_pkg::CCCH_HSOUT;
    end else if (mat) begin
      mode_now = ccch_pkg::CCCH_SWTIMER;
    end else begin
      mode_now = ccch_pkg::CCCH_IDLE;
    end
  end

  // ****************************************************************
  // pin synchroniser and edge detect
  // ****************************************************************
  // sync1 feeds sync2 only; edges come from sync2 against sync3
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      sync3_reg <= 1'b0;
    end else begin
      sync1_reg <= channel_pin_i;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  logic rise;
  logic fall;
  logic cap_evt;
  assign rise    = sync2_reg && !sync3_reg;
  assign fall    = !sync2_reg && sync3_reg;
  // a level shorter than one clock may slip through the sampler
  assign cap_evt = (mode_now == ccch_pkg::CCCH_CAPTURE) &&
                   ((capp && rise) || (capn && fall));

  // ****************************************************************
  // counter change detection and match terms
  // ****************************************************************
  // a tick is a cycle where the running counter took a new value; the
  // tracker follows every cycle so one change can never fire twice
  logic [10:0] nmask;
  logic        tick;
  logic        m16;
  logic        m8;
  logic        mn;
  logic        ovf_n;
  assign tick = count_en_i && (counter_i != cnt_prev_reg);

  always_comb begin
    case (cycle_length_select_i)
      `CCCH_CYCLE_LENGTH_SELECT_8BIT:  nmask = 11'h0FF;
      `CCCH_CYCLE_LENGTH_SELECT_9BIT:  nmask = 11'h1FF;
      `CCCH_CYCLE_LENGTH_SELECT_10BIT: nmask = 11'h3FF;
      default:           nmask = 11'h7FF;
    endcase
  end

  assign m16   = tick && (counter_i == cmp_reg);
  assign m8    = tick && (counter_i[7:0] == cmp_reg[7:0]);
  assign mn    = tick && ((counter_i[10:0] & nmask) == (cmp_reg[10:0] & nmask));
  // overflow of bit n: low n bits just wrapped to zero
  assign ovf_n = tick && ((counter_i[10:0] & nmask) == 11'h000) &&
                 ((cnt_prev_reg[10:0] & nmask) == nmask);

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_prev_reg <= 16'h0000;
    end else begin
      cnt_prev_reg <= counter_i;
    end
  end

  logic pwm_on;
  assign pwm_on = (mode_now == ccch_pkg::CCCH_PWM) && !mode_reg[`CCCH_MODE_PWM16];

  // ****************************************************************
  // mode register: software write, comparator enable side effects
  // ****************************************************************
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_reg <= `CCCH_MODE_RESET;
    end else if (mode_wr_i) begin
      mode_reg <= mode_wdata_i;
    end else if (low_wr_i && !reload_register_select_i) begin
      mode_reg[`CCCH_MODE_ECOM] <= 1'b0;
    end else if (high_wr_i && !reload_register_select_i) begin
      mode_reg[`CCCH_MODE_ECOM] <= 1'b1;
    end
  end

  // ****************************************************************
  // auto-reload register
  // ****************************************************************
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reload_reg <= `CCCH_RELOAD_RESET;
    end else if (reload_register_select_i && low_wr_i) begin
      reload_reg[7:0] <= byte_wdata_i;
    end else if (reload_register_select_i && high_wr_i) begin
      reload_reg[15:8] <= byte_wdata_i;
    end
  end

  // ****************************************************************
  // capture/compare register
  // ****************************************************************
  // software write wins over hardware updates in the same cycle
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cmp_reg <= `CCCH_CMP_RESET;
    end else if (!reload_register_select_i && low_wr_i) begin
      cmp_reg[7:0] <= byte_wdata_i;
    end else if (!reload_register_select_i && high_wr_i) begin
      cmp_reg[15:8] <= byte_wdata_i;
    end else if (cap_evt) begin
      cmp_reg <= counter_i;
    end else if ((mode_now == ccch_pkg::CCCH_FREQ) && ecom && m8) begin
      // high byte zero wraps the sum to the same value: 256 counter ticks
      cmp_reg[7:0] <= cmp_reg[7:0] + cmp_reg[15:8];
    end else if (pwm_on && ovf_n) begin
      if (cycle_length_select_i == `CCCH_CYCLE_LENGTH_SELECT_8BIT) begin
        cmp_reg[7:0] <= cmp_reg[15:8];
      end else begin
        cmp_reg <= reload_reg;
      end
    end
  end

  // ****************************************************************
  // channel pin output
  // ****************************************************************
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_reg <= 1'b0;
    end else if (pwm_on) begin
      if (!ecom) begin
        pin_reg <= 1'b0;
      end else if (ovf_n) begin
        pin_reg <= 1'b0;
      end else if (mn) begin
        pin_reg <= 1'b1;
      end
    end else if ((mode_now == ccch_pkg::CCCH_HSOUT) && ecom && mat && m16) begin
      pin_reg <= !pin_reg;
    end else if ((mode_now == ccch_pkg::CCCH_FREQ) && ecom && m8) begin
      pin_reg <= !pin_reg;
    end
  end

  // ****************************************************************
  // event and overflow flags: a set beats a clear in the same cycle
  // ****************************************************************
  logic evt_set;
  always_comb begin
    case (mode_now)
      ccch_pkg::CCCH_CAPTURE: evt_set = cap_evt;
      ccch_pkg::CCCH_SWTIMER: evt_set = ecom && m16;
      ccch_pkg::CCCH_HSOUT:   evt_set = ecom && mat && m16;
      ccch_pkg::CCCH_FREQ:    evt_set = ecom && mat && m16;
      ccch_pkg::CCCH_PWM:     evt_set = pwm_on && ecom && mat && mn;
      default:                evt_set = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flag_reg <= 1'b0;
    end else if (evt_set) begin
      flag_reg <= 1'b1;
    end else if (event_flag_clr_i) begin
      flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ovf_reg <= 1'b0;
    end else if (pwm_on && ovf_n) begin
      ovf_reg <= 1'b1;
    end else if (overflow_flag_clr_i) begin
      ovf_reg <= 1'b0;
    end
  end

  // ****************************************************************
  // registered outputs
  // ****************************************************************
  logic irq_next;
  assign irq_next = (flag_reg && mode_reg[`CCCH_MODE_INT_EN]) ||
                    (ovf_reg && overflow_int_en_i);

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_o                        <= 1'b0;
      channel_pin_o                <= 1'b0;
      channel_mode_register_o      <= `CCCH_MODE_RESET;
      compare_low_byte_o           <= 8'h00;
      compare_high_byte_o          <= 8'h00;
      channel_event_flag_o         <= 1'b0;
      intermediate_overflow_flag_o <= 1'b0;
    end else begin
      irq_o                        <= irq_next;
      channel_pin_o                <= pin_reg;
      channel_mode_register_o      <= mode_reg;
      compare_low_byte_o           <= reload_register_select_i ? reload_reg[7:0]
                                                               : cmp_reg[7:0];
      compare_high_byte_o          <= reload_register_select_i ? reload_reg[15:8]
                                                                : cmp_reg[15:8];
      channel_event_flag_o         <= flag_reg;
      intermediate_overflow_flag_o <= ovf_reg;
    end
  end

endmodule // ccch_channel

// ### design/ccch_pkg.sv
/*
  types for the counter-array capture/compare channel.
  assumes nothing beyond a SystemVerilog compiler.
*/
package ccch_pkg;

  // ****************************************************************
  // operating modes decoded from the mode bits
  // ****************************************************************
  typedef enum logic [2:0] {
    CCCH_IDLE    = 3'h0,
    CCCH_CAPTURE = 3'h1,
    CCCH_SWTIMER = 3'h3,
    CCCH_HSOUT   = 3'h2,
    CCCH_FREQ    = 3'h6,
    CCCH_PWM     = 3'h7
  } ccch_mode_t;

endpackage

// ### design/ccch_regs.svh
/*
  constants for one counter-array capture/compare channel: mode bit
  positions, cycle-length codes and reset values.
  assumes it is included by bare name from the channel design files.
*/
`ifndef CCCH_REGS_SVH
`define CCCH_REGS_SVH

// ****************************************************************
// channel mode register bit positions
// ****************************************************************
`define CCCH_MODE_INT_EN      0
`define CCCH_MODE_PWM         1
`define CCCH_MODE_TOG         2
`define CCCH_MODE_MAT         3
`define CCCH_MODE_CAPN        4
`define CCCH_MODE_CAPP        5
`define CCCH_MODE_ECOM        6
`define CCCH_MODE_PWM16       7

// ****************************************************************
// cycle-length codes and reset values
// ****************************************************************
`define CCCH_CYCLE_LENGTH_SELECT_8BIT       2'h0
`define CCCH_CYCLE_LENGTH_SELECT_9BIT       2'h1
`define CCCH_CYCLE_LENGTH_SELECT_10BIT      2'h2
`define CCCH_CYCLE_LENGTH_SELECT_11BIT      2'h3
`define CCCH_MODE_RESET       8'h00
`define CCCH_CMP_RESET        16'h0000
`define CCCH_RELOAD_RESET     16'h0000

`endif

// ### dv/ccch_channel_assertions.sv
/*
  concurrent checks on the capture/compare channel ports.
  assumes it is bound to ccch_channel and sees its ports only.
*/
`timescale 1ns/1ns
module ccch_chk (
  // clock and reset
  input wire logic       core_clk_i,
  input wire logic       rst_n_i,
  // writes and clears
  input wire logic       mode_wr_i,
  input wire logic       low_wr_i,
  input wire logic       high_wr_i,
  input wire logic [7:0] byte_wdata_i,
  input wire logic       reload_register_select_i,
  input wire logic       event_flag_clr_i,
  input wire logic       overflow_flag_clr_i,
  // pin and status
  input wire logic       channel_pin_i,
  input wire logic       channel_pin_o,
  input wire logic [7:0] channel_mode_register_o,
  input wire logic [7:0] compare_high_byte_o,
  input wire logic       channel_event_flag_o,
  input wire logic       intermediate_overflow_flag_o,
  input wire logic       irq_o
);
  logic [7:0] m;

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  // short alias for the mode readback
  assign m = channel_mode_register_o;

  high_sets_en_a: assert property (
    high_wr_i && !low_wr_i && !mode_wr_i && !reload_register_select_i |-> ##2 m[6])
    else $error("high byte write left comparator disabled");
  low_clears_en_a: assert property (
    low_wr_i && !high_wr_i && !mode_wr_i && !reload_register_select_i |-> ##2 !m[6])
    else $error("low byte write left comparator enabled");
  high_data_a: assert property (
    high_wr_i && !reload_register_select_i ##1 !reload_register_select_i
    |-> ##1 compare_high_byte_o == $past(byte_wdata_i, 2))
    else $error("high byte readback wrong");
  flag_sticky_a: assert property (
    $fell(channel_event_flag_o) |-> $past(event_flag_clr_i, 2))
    else $error("event flag dropped without clear");
  ovf_sticky_a: assert property (
    $fell(intermediate_overflow_flag_o) |-> $past(overflow_flag_clr_i, 2))
    else $error("overflow flag dropped without clear");
  irq_raise_a: assert property (
    channel_event_flag_o && m[0] |-> ##[0:1] irq_o)
    else $error("enabled event flag raised no irq");
  irq_quiet_a: assert property (
    (!channel_event_flag_o && !intermediate_overflow_flag_o) [*2] |-> !irq_o)
    else $error("irq without any flag");
  pwm_off_a: assert property (
    (m[1] && !m[2] && !m[6] && !m[7]) [*3] |-> !channel_pin_o)
    else $error("pwm output high with comparator off");
  hold_pin_a: assert property (
    (m[2] && !m[1] && !m[6]) [*3] |-> $stable(channel_pin_o))
    else $error("pin moved with comparator off");
  capture_a: assert property (
    m[5] && $rose(channel_pin_i) |-> ##[3:6] channel_event_flag_o)
    else $error("rising edge not captured");
endmodule // ccch_chk

bind ccch_channel ccch_chk u_chk (.core_clk_i, .rst_n_i, .mode_wr_i, .low_wr_i,
  .high_wr_i, .byte_wdata_i, .reload_register_select_i, .event_flag_clr_i,
  .overflow_flag_clr_i, .channel_pin_i, .channel_pin_o, .channel_mode_register_o,
  .compare_high_byte_o, .channel_event_flag_o, .intermediate_overflow_flag_o, .irq_o);

// ### dv/ccch_pin_model.sv
/*
  model of the external source on the channel pin.
  assumes the bench asks for levels; each level stands two clocks at least.
*/
`timescale 1ns/1ns
module ccch_pin_model (
  // clock
  input  wire logic core_clk_i,
  // level asked for by the bench
  input  wire logic level_i,
  // level driven onto the channel pin
  output logic      channel_pin_o
);
  logic [1:0] held_reg;

  initial begin
    held_reg = 2'h0;
    channel_pin_o = 1'b0;
  end

  // a new level is applied only once the old one has stood two clocks
  always @(posedge core_clk_i) begin
    if (level_i != channel_pin_o && held_reg >= 2'h2) begin
      channel_pin_o <= #1 level_i;
      held_reg <= 2'h0;
    end else if (held_reg != 2'h3) begin
      held_reg <= held_reg + 2'h1;
    end
  end
endmodule // ccch_pin_model

// ### dv/tb.sv
/*
  self-checking bench for the capture/compare channel.
  assumes the channel design, its checker and the pin model are compiled first.
*/
`timescale 1ns/1ns
module tb;
  logic       core_clk_i, rst_n_i, count_en_i, reload_register_select_i;
  logic       overflow_int_en_i, overflow_flag_clr_i, event_flag_clr_i;
  logic       mode_wr_i, low_wr_i, high_wr_i, lvl, p, channel_pin_i;
  logic       channel_pin_o, channel_event_flag_o, intermediate_overflow_flag_o, irq_o;
  logic [1:0] cycle_length_select_i;
  logic [7:0] mode_wdata_i, byte_wdata_i, d, e, h;
  logic [7:0] channel_mode_register_o, compare_low_byte_o, compare_high_byte_o;
  logic [15:0] counter_i, v;
  int         err_count, check_count, k, n, seed;

  ccch_channel uut (.core_clk_i, .rst_n_i, .counter_i, .count_en_i, .cycle_length_select_i,
    .reload_register_select_i, .overflow_int_en_i, .overflow_flag_clr_i, .mode_wr_i,
    .mode_wdata_i, .low_wr_i, .high_wr_i, .byte_wdata_i, .event_flag_clr_i, .channel_pin_i,
    .channel_pin_o, .channel_mode_register_o, .compare_low_byte_o, .compare_high_byte_o,
    .channel_event_flag_o, .intermediate_overflow_flag_o, .irq_o);
  ccch_pin_model pin_src (.core_clk_i, .level_i(lvl), .channel_pin_o(channel_pin_i));

  // free-running clock
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  // expected capture for an edge given {rising, falling} enables
  function automatic logic exp_cap(input logic [1:0] en, input logic rise);
    return rise ? en[1] : en[0];
  endfunction
  // expected low byte after a frequency-output match
  function automatic logic [7:0] exp_freq(input logic [7:0] lo, input logic [7:0] hi);
    return lo + hi;
  endfunction

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge core_clk_i);
    #1;
  endtask
  // kind: 0 low byte, 1 high byte, 2 mode
  task automatic wr(input int kind, input logic [7:0] dat);
    byte_wdata_i = dat;
    mode_wdata_i = dat;
    low_wr_i = (kind == 0);
    high_wr_i = (kind == 1);
    mode_wr_i = (kind == 2);
    cyc(1);
    {low_wr_i, high_wr_i, mode_wr_i} = 3'h0;
    cyc(1);
  endtask
  task automatic load(input logic [7:0] lo, input logic [7:0] hi, input logic [7:0] md);
    wr(0, lo);
    wr(1, hi);
    wr(2, md);
    cyc(2);
  endtask
  task automatic clr();
    {event_flag_clr_i, overflow_flag_clr_i} = 2'h3;
    cyc(1);
    {event_flag_clr_i, overflow_flag_clr_i} = 2'h0;
    cyc(2);
  endtask
  // counter steps to a, then to b, then outputs settle
  task automatic step(input logic [15:0] a, input logic [15:0] b);
    counter_i = a;
    cyc(1);
    counter_i = b;
    cyc(4);
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // bound on the whole run
  initial begin
    #900000;
    err_count++;
    report_and_stop();
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    seed = $urandom(7);
    {err_count, check_count, lvl, counter_i, cycle_length_select_i} = 0;
    {reload_register_select_i, overflow_int_en_i, overflow_flag_clr_i} = 3'h0;
    {event_flag_clr_i, mode_wr_i, low_wr_i, high_wr_i, mode_wdata_i, byte_wdata_i} = 0;
    count_en_i = 1'b1;
    rst_n_i = 1'b0;
    cyc(6);
    rst_n_i = 1'b1;
    // byte writes and comparator enable side effects
    {d, e} = 16'($urandom);
    wr(1, d);
    chk(channel_mode_register_o[6], 1'b1);
    wr(0, e);
    chk(channel_mode_register_o[6], 1'b0);
    chk({compare_high_byte_o, compare_low_byte_o}, {d, e});
    reload_register_select_i = 1'b1;
    wr(0, ~e);
    wr(1, ~d);
    chk({compare_high_byte_o, compare_low_byte_o}, ~{d, e});
    reload_register_select_i = 1'b0;
    cyc(2);
    chk({compare_high_byte_o, compare_low_byte_o}, {d, e});
    // capture on each edge selection, rising then falling
    for (k = 1; k < 4; k++) begin
      wr(2, {2'h0, k[1:0], 4'h1});
      repeat (2) begin
        v = 16'($urandom);
        counter_i = v;
        lvl = !lvl;
        cyc(8);
        chk(channel_event_flag_o, exp_cap(k[1:0], lvl));
        if (exp_cap(k[1:0], lvl)) begin
          chk({compare_high_byte_o, compare_low_byte_o}, v);
          chk(irq_o, 1'b1);
        end
        clr();
      end
    end
    // software timer
    v = 16'($urandom);
    load(v[7:0], v[15:8], 8'h49);
    step(v - 16'h2, v - 16'h1);
    chk(channel_event_flag_o, 1'b0);
    // a counter change while the run enable is low is no event
    count_en_i = 1'b0;
    step(v - 16'h1, v);
    chk(channel_event_flag_o, 1'b0);
    count_en_i = 1'b1;
    step(v - 16'h1, v);
    chk(channel_event_flag_o, 1'b1);
    clr();
    // high-speed output, then comparator disabled by a low write
    load(v[7:0], v[15:8], 8'h4C);
    p = channel_pin_o;
    step(v - 16'h1, v);
    chk({channel_pin_o, channel_event_flag_o}, {!p, 1'b1});
    wr(0, v[7:0]);
    step(v - 16'h1, v);
    chk(channel_pin_o, !p);
    // frequency output with zero and random high byte, match flag on
    for (k = 0; k < 2; k++) begin
      {d, h} = 16'($urandom);
      if (k == 0) h = 8'h00;
      clr();
      load(d, h, 8'h4E);
      p = channel_pin_o;
      step({8'h00, d - 8'h01}, {8'h00, d});
      chk(channel_pin_o, !p);
      chk(compare_low_byte_o, exp_freq(d, h));
      chk(channel_event_flag_o, h == 8'h00);
    end
    // 8-bit pwm: match, overflow, reload, then comparator off
    clr();
    overflow_int_en_i = 1'b1;
    d = 8'($urandom % 253 + 2);
    h = 8'($urandom);
    load(d, h, 8'h4A);
    step({8'h00, d - 8'h01}, {8'h00, d});
    chk({channel_pin_o, channel_event_flag_o}, 2'h3);
    step(16'h00FF, 16'h0100);
    chk({channel_pin_o, intermediate_overflow_flag_o}, 2'h1);
    chk(compare_low_byte_o, h);
    chk(irq_o, 1'b1);
    clr();
    wr(0, 8'h10);
    step(16'h020F, 16'h0210);
    chk(channel_pin_o, 1'b0);
    // 9..11-bit pwm on the shared cycle-length field
    for (k = 1; k < 4; k++) begin
      cycle_length_select_i = k[1:0];
      n = 8 + k;
      v = 16'($urandom % ((1 << n) - 2) + 1);
      load(v[7:0], v[15:8], 8'h42);
      step(v - 16'h1, v);
      chk(channel_pin_o, 1'b1);
      step(16'((1 << n) - 1), 16'(1 << n));
      chk({channel_pin_o, intermediate_overflow_flag_o}, 2'h1);
      clr();
    end
    report_and_stop();
  end
endmodule // tb
